// ===== rtl/frau_pkg.sv
// frau_pkg: opcodes, float constants, reset values and result bit positions for the float unit
// assumes ieee-754 single precision operands presented by the scan engine
package frau_pkg;
	typedef enum logic [2:0] {
		FRAU_OP_RANGE,
		FRAU_OP_DEG2RAD,
		FRAU_OP_RAD2DEG,
		FRAU_OP_ADD,
		FRAU_OP_SUB
	} frau_op_t;
	localparam logic [31:0] FRAU_PI_OVER_180 = 32'h3c8efa35;
	localparam logic [31:0] FRAU_180_OVER_PI = 32'h42652ee1;
	localparam logic [2:0] FRAU_RES_RESET = 3'h0;
	localparam logic [31:0] FRAU_RESULT_RESET = 32'h00000000;
	localparam int FRAU_RES_BELOW = 0;
	localparam int FRAU_RES_WITHIN = 1;
	localparam int FRAU_RES_ABOVE = 2;
endpackage

// ===== rtl/frau_fmath.sv
// frau_fmath: registered single-precision add and multiply core
// assumes operands stable while start is high; answer one cycle later
// no nan or infinity handling; denormals flush to zero, truncating rounding
`timescale 1ns/10ps
`default_nettype none
module frau_fmath (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic start,
	input wire logic mul_sel,
	input wire logic [31:0] a,
	input wire logic [31:0] b,
	output logic [31:0] y,
	output logic done
);
	logic [31:0] y_r, y_nxt;
	logic done_r;
	logic [31:0] add_y, mul_y;
	always_comb begin
		logic [31:0] big, sml;
		logic [8:0] d;
		logic [26:0] ma, mb;
		logic [27:0] s;
		logic [7:0] e;
		int k;
		big = 32'h0;
		sml = 32'h0;
		d = 9'h0;
		ma = 27'h0;
		mb = 27'h0;
		s = 28'h0;
		e = 8'h0;
		k = 0;
		add_y = 32'h0;
		if (a[30:0] >= b[30:0]) begin
			big = a;
			sml = b;
		end else begin
			big = b;
			sml = a;
		end
		d = {1'b0, big[30:23]} - {1'b0, sml[30:23]};
		ma = (big[30:23] == 8'h0) ? 27'h0 : {1'b1, big[22:0], 3'h0};
		mb = (sml[30:23] == 8'h0) ? 27'h0 : {1'b1, sml[22:0], 3'h0};
		mb = (d > 9'd26) ? 27'h0 : (mb >> d);
		s = (big[31] == sml[31]) ? ({1'b0, ma} + {1'b0, mb}) : ({1'b0, ma} - {1'b0, mb});
		e = big[30:23];
		if (s[27]) begin
			add_y = {big[31], e + 8'h1, s[26:4]};
		end else begin
			for (k = 26; k >= 0; k--) begin
				if (s[k] && add_y == 32'h0 && (26 - k) < e) begin
					add_y = {big[31], e - 8'(26 - k), 23'((s[26:0] << (26 - k)) >> 3)};
				end
			end
		end
	end
	always_comb begin
		logic [47:0] p;
		logic [9:0] ex;
		p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
		ex = {2'h0, a[30:23]} + {2'h0, b[30:23]} - 10'd127 + {9'h0, p[47]};
		if (a[30:23] == 8'h0 || b[30:23] == 8'h0 || ex[9] || ex == 10'h0) begin
			mul_y = {a[31] ^ b[31], 31'h0};
		end else if (ex[8]) begin
			mul_y = {a[31] ^ b[31], 8'hfe, 23'h7fffff};
		end else begin
			mul_y = {a[31] ^ b[31], ex[7:0], p[47] ? p[46:24] : p[45:23]};
		end
	end
	always_comb begin
		y_nxt = y_r;
		if (start) begin
			y_nxt = mul_sel ? mul_y : add_y;
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			y_r <= 32'h0;
			done_r <= 1'b0;
		end else begin
			y_r <= y_nxt;
			done_r <= start;
		end
	end
	assign y = y_r;
	assign done = done_r;
endmodule
`default_nettype wire

// ===== rtl/frau_unit.sv
// frau_unit: float range compare, angle conversion, add and subtract
// assumes the scan engine presents one instruction per scan_strobe pulse
// Function
// - range compare writes value against limits into three result bits
// - decimal or hex constant limits are converted to float first
// - lower limit above upper means lower limit used as both bounds
// - each true execution sets exactly one of three result bits
// - condition false leaves result bits unchanged
// - degree to radian multiplies source by pi over 180
// - radian to degree multiplies source by 180 over pi
// - 32-bit only, low word in lower-numbered register
// - add sums two sources into destination pair
// - subtract takes second source from first
// - constant add or subtract sources converted to float first
// - continuous variant operates every scan while condition true
`timescale 1ns/10ps
`default_nettype none
module frau_unit (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic scan_strobe,
	input wire frau_pkg::frau_op_t op_sel,
	input wire logic pulse_variant,
	input wire logic condition_input_bit,
	input wire logic [15:0] src1_lo,
	input wire logic [15:0] src1_hi,
	input wire logic src1_is_int,
	input wire logic [15:0] src2_lo,
	input wire logic [15:0] src2_hi,
	input wire logic src2_is_int,
	input wire logic [15:0] src3_lo,
	input wire logic [15:0] src3_hi,
	input wire logic range_clear,
	output logic [2:0] result_relay_base,
	output logic [15:0] dest_lo,
	output logic [15:0] dest_hi,
	output logic dest_we,
	output logic busy
);
	import frau_pkg::*;
	typedef enum logic [1:0] {FRAU_IDLE, FRAU_CALC, FRAU_WAIT} frau_st_t;
	frau_st_t st_r, st_nxt;
	logic [2:0] res_r, res_nxt;
	logic [31:0] dst_r, dst_nxt;
	logic we_r, we_nxt;
	logic busy_r, busy_nxt;
	logic cond_prev_r, cond_prev_nxt;
	logic [31:0] a_r, a_nxt, b_r, b_nxt;
	logic mul_r, mul_nxt;
	logic fm_start;
	logic [31:0] fm_y;
	logic fm_done;
	logic [31:0] op1, op2, op3;
	logic fire;

	// signed 32-bit integer to float, truncating low bits
	function automatic logic [31:0] frau_i2f(input logic [31:0] v);
		logic [31:0] m;
		logic [31:0] r;
		int i;
		m = v[31] ? (32'h0 - v) : v;
		r = 32'h0;
		for (i = 0; i < 32; i++) begin
			if (m[i]) begin
				r = {v[31], 8'(127 + i), 23'((m << (31 - i)) >> 8)};
			end
		end
		return r;
	endfunction

	// float a less than float b, ordered compare, +0 equals -0
	function automatic logic frau_flt(input logic [31:0] a, input logic [31:0] b);
		logic r;
		if (a[30:0] == 31'h0 && b[30:0] == 31'h0) begin
			r = 1'b0;
		end else if (a[31] != b[31]) begin
			r = a[31];
		end else if (a[31]) begin
			r = a[30:0] > b[30:0];
		end else begin
			r = a[30:0] < b[30:0];
		end
		return r;
	endfunction

	// low word sits in the lower-numbered register
	assign op1 = src1_is_int ? frau_i2f({src1_hi, src1_lo}) : {src1_hi, src1_lo};
	assign op2 = src2_is_int ? frau_i2f({src2_hi, src2_lo}) : {src2_hi, src2_lo};
	assign op3 = {src3_hi, src3_lo};
	// pulse form only on the rising scan, continuous form every true scan
	assign fire = scan_strobe && condition_input_bit &&
		(!pulse_variant || !cond_prev_r);

	always_comb begin
		logic [31:0] lo, hi;
		lo = op1;
		hi = op2;
		st_nxt = st_r;
		res_nxt = res_r;
		dst_nxt = dst_r;
		we_nxt = 1'b0;
		busy_nxt = busy_r;
		cond_prev_nxt = cond_prev_r;
		a_nxt = a_r;
		b_nxt = b_r;
		mul_nxt = mul_r;
		fm_start = 1'b0;
		// the engine's clear is honoured only when no compare lands this cycle
		if (range_clear) begin
			res_nxt = FRAU_RES_RESET;
		end
		unique case (st_r)
			FRAU_IDLE: begin
				if (scan_strobe) begin
					cond_prev_nxt = condition_input_bit;
				end
				if (fire) begin
					unique case (op_sel)
						FRAU_OP_RANGE: begin
							if (frau_flt(op2, op1)) begin
								hi = op1;
							end
							res_nxt = 3'h0;
							if (frau_flt(op3, lo)) begin
								res_nxt[FRAU_RES_BELOW] = 1'b1;
							end else if (frau_flt(hi, op3)) begin
								res_nxt[FRAU_RES_ABOVE] = 1'b1;
							end else begin
								res_nxt[FRAU_RES_WITHIN] = 1'b1;
							end
						end
						FRAU_OP_DEG2RAD: begin
							a_nxt = op1;
							b_nxt = FRAU_PI_OVER_180;
							mul_nxt = 1'b1;
						end
						FRAU_OP_RAD2DEG: begin
							a_nxt = op1;
							b_nxt = FRAU_180_OVER_PI;
							mul_nxt = 1'b1;
						end
						FRAU_OP_ADD: begin
							a_nxt = op1;
							b_nxt = op2;
							mul_nxt = 1'b0;
						end
						FRAU_OP_SUB: begin
							a_nxt = op1;
							b_nxt = {~op2[31], op2[30:0]};
							mul_nxt = 1'b0;
						end
						default: begin
							// unknown opcode: no action, a pending clear still lands
						end
					endcase
					// only real arithmetic codes start the datapath, never stale operands
					if (op_sel inside {FRAU_OP_DEG2RAD, FRAU_OP_RAD2DEG, FRAU_OP_ADD, FRAU_OP_SUB}) begin
						st_nxt = FRAU_CALC;
						busy_nxt = 1'b1;
					end
				end
			end
			FRAU_CALC: begin
				fm_start = 1'b1;
				st_nxt = FRAU_WAIT;
			end
			FRAU_WAIT: begin
				if (fm_done) begin
					dst_nxt = fm_y;
					we_nxt = 1'b1;
					busy_nxt = 1'b0;
					st_nxt = FRAU_IDLE;
				end
			end
		endcase
		// condition false: only range_clear above touched the relays
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_r <= FRAU_IDLE;
			res_r <= FRAU_RES_RESET;
			dst_r <= FRAU_RESULT_RESET;
			we_r <= 1'b0;
			busy_r <= 1'b0;
			cond_prev_r <= 1'b0;
			a_r <= 32'h0;
			b_r <= 32'h0;
			mul_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			res_r <= res_nxt;
			dst_r <= dst_nxt;
			we_r <= we_nxt;
			busy_r <= busy_nxt;
			cond_prev_r <= cond_prev_nxt;
			a_r <= a_nxt;
			b_r <= b_nxt;
			mul_r <= mul_nxt;
		end
	end

	frau_fmath u_fmath (
		.clk_sys(clk_sys),
		.rst(rst),
		.start(fm_start),
		.mul_sel(mul_r),
		.a(a_r),
		.b(b_r),
		.y(fm_y),
		.done(fm_done)
	);

	assign result_relay_base = res_r;
	assign dest_lo = dst_r[15:0];
	assign dest_hi = dst_r[31:16];
	assign dest_we = we_r;
	assign busy = busy_r;
endmodule
`default_nettype wire

// ===== tb/frau_scan_store.sv
// frau_scan_store: scan engine side, keeps the destination register pair
// assumes dest words are valid in the cycle dest_we is high
`timescale 1ns/10ps
`default_nettype none
module frau_scan_store (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic dest_we,
	input wire logic [15:0] dest_lo,
	input wire logic [15:0] dest_hi,
	output logic [31:0] stored
);
	// high word sits in the higher-numbered register of the pair
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stored <= 32'h0;
		end else if (dest_we) begin
			stored <= {dest_hi, dest_lo};
		end
	end
endmodule
`default_nettype wire

// ===== tb/frau_unit_checker.sv
// frau_unit_checker: timing and hold properties of the float unit
// assumes a single clk_sys domain with rst active high
`timescale 1ns/10ps
`default_nettype none
module frau_unit_checker (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic scan_strobe,
	input wire frau_pkg::frau_op_t op_sel,
	input wire logic pulse_variant,
	input wire logic condition_input_bit,
	input wire logic range_clear,
	input wire logic [2:0] result_relay_base,
	input wire logic [15:0] dest_lo,
	input wire logic [15:0] dest_hi,
	input wire logic dest_we,
	input wire logic busy
);
	import frau_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic go;
	assign go = scan_strobe && !busy;
	sequence s_arith_go;
		go && condition_input_bit && !pulse_variant &&
			op_sel inside {FRAU_OP_DEG2RAD, FRAU_OP_RAD2DEG, FRAU_OP_ADD, FRAU_OP_SUB};
	endsequence
	// busy covers the two datapath cycles and drops with the dest_we pulse
	sequence s_busy_run;
		busy [*2] ##1 !busy;
	endsequence
	a_relay_onehot: assert property (go && op_sel == FRAU_OP_RANGE && condition_input_bit
		&& !pulse_variant |=> $onehot(result_relay_base)) else $error("relays not one-hot");
	a_busy_span: assert property (s_arith_go |=> s_busy_run) else $error("busy span wrong");
	a_dest_timing: assert property (s_arith_go |-> ##3 dest_we) else $error("dest_we late");
	a_we_single: assert property (dest_we |=> !dest_we) else $error("dest_we too long");
	a_relay_idle: assert property (!go && !range_clear |=> $stable(result_relay_base))
		else $error("relays moved while idle");
	a_cond_hold: assert property (scan_strobe && !condition_input_bit && !range_clear
		|=> $stable(result_relay_base)) else $error("relays moved with condition false");
	a_clear_zero: assert property (range_clear && !(go && op_sel == FRAU_OP_RANGE)
		|=> result_relay_base == 3'h0) else $error("relays not cleared");
	a_cond_noop: assert property (go && !condition_input_bit |=> !busy)
		else $error("busy with condition false");
	a_dest_change: assert property ($changed({dest_hi, dest_lo}) |-> dest_we)
		else $error("dest moved without dest_we");
endmodule
bind frau_unit frau_unit_checker i_frau_unit_checker (.clk_sys(clk_sys), .rst(rst),
	.scan_strobe(scan_strobe), .op_sel(op_sel), .pulse_variant(pulse_variant),
	.condition_input_bit(condition_input_bit), .range_clear(range_clear),
	.result_relay_base(result_relay_base), .dest_lo(dest_lo), .dest_hi(dest_hi),
	.dest_we(dest_we), .busy(busy));
`default_nettype wire

// ===== tb/test_float_range_addsub_angle_unit.sv
// test_float_range_addsub_angle_unit: directed scenarios for the float unit
// assumes exact-value operands so truncating arithmetic gives exact results
`timescale 1ns/10ps
`default_nettype none
module test_float_range_addsub_angle_unit;
	import frau_pkg::*;
	localparam logic [31:0] FH = 32'h3f000000, F1 = 32'h3f800000, F2 = 32'h40000000;
	localparam logic [31:0] F3 = 32'h40400000, F4 = 32'h40800000, F5 = 32'h40a00000;
	localparam logic [31:0] F10 = 32'h41200000, F20 = 32'h41a00000;
	logic clk_sys = 0, rst = 1, scan_strobe = 0, pv = 0, cond = 0, i1 = 0, i2 = 0, clr = 0;
	logic dest_we, busy, we_seen;
	frau_op_t op_sel = FRAU_OP_RANGE;
	logic [31:0] s1 = 0, s2 = 0, s3 = 0, stored;
	logic [15:0] dest_lo, dest_hi;
	logic [2:0] rel;
	int n_mismatch = 0, n_tests = 0;
	always #2 clk_sys = ~clk_sys;
	frau_unit i_frau_unit (.clk_sys(clk_sys), .rst(rst), .scan_strobe(scan_strobe),
		.op_sel(op_sel), .pulse_variant(pv), .condition_input_bit(cond),
		.src1_lo(s1[15:0]), .src1_hi(s1[31:16]), .src1_is_int(i1),
		.src2_lo(s2[15:0]), .src2_hi(s2[31:16]), .src2_is_int(i2),
		.src3_lo(s3[15:0]), .src3_hi(s3[31:16]), .range_clear(clr),
		.result_relay_base(rel), .dest_lo(dest_lo), .dest_hi(dest_hi),
		.dest_we(dest_we), .busy(busy));
	frau_scan_store i_frau_scan_store (.clk_sys(clk_sys), .rst(rst), .dest_we(dest_we),
		.dest_lo(dest_lo), .dest_hi(dest_hi), .stored(stored));
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one strobe, then six cycles: covers the three-cycle arithmetic answer
	task automatic ex(input frau_op_t op, input logic p, c, a_int, b_int,
		input logic [31:0] a, b, v);
		@(posedge clk_sys);
		op_sel <= op;
		pv <= p;
		cond <= c;
		i1 <= a_int;
		i2 <= b_int;
		s1 <= a;
		s2 <= b;
		s3 <= v;
		scan_strobe <= 1'b1;
		@(posedge clk_sys);
		scan_strobe <= 1'b0;
		we_seen = 1'b0;
		repeat (6) begin
			@(posedge clk_sys);
			#1;
			if (dest_we === 1'b1) we_seen = 1'b1;
		end
	endtask
	task automatic t_range;
		ex(FRAU_OP_RANGE, 0, 1, 0, 0, F1, F10, FH);
		chk("below", rel, 3'h1);
		ex(FRAU_OP_RANGE, 0, 1, 0, 0, F1, F10, F5);
		chk("within", rel, 3'h2);
		ex(FRAU_OP_RANGE, 0, 1, 0, 0, F1, F10, F10);
		chk("upper edge", rel, 3'h2);
		ex(FRAU_OP_RANGE, 0, 1, 0, 0, F1, F10, F20);
		chk("above", rel, 3'h4);
		ex(FRAU_OP_RANGE, 0, 1, 1, 1, 32'h1, 32'ha, F5);
		chk("int limits", rel, 3'h2);
		ex(FRAU_OP_RANGE, 0, 1, 1, 1, 32'h1, 32'ha, F20);
		chk("int upper", rel, 3'h4);
	endtask
	task automatic t_swap_hold;
		ex(FRAU_OP_RANGE, 0, 1, 0, 0, F10, F1, F5);
		chk("swapped below", rel, 3'h1);
		ex(FRAU_OP_RANGE, 0, 1, 0, 0, F10, F1, F10);
		chk("swapped equal", rel, 3'h2);
		ex(FRAU_OP_RANGE, 0, 0, 0, 0, F1, F10, F20);
		chk("cond off hold", rel, 3'h2);
		@(posedge clk_sys);
		clr <= 1'b1;
		@(posedge clk_sys);
		clr <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk("cleared", rel, 3'h0);
	endtask
	task automatic t_arith;
		ex(FRAU_OP_ADD, 0, 1, 0, 0, F1, F2, 0);
		chk("add", stored, F3);
		ex(FRAU_OP_SUB, 0, 1, 0, 0, F3, F1, 0);
		chk("sub", stored, F2);
		ex(FRAU_OP_SUB, 0, 1, 1, 0, 32'h3, F1, 0);
		chk("int sub", stored, F2);
		ex(FRAU_OP_DEG2RAD, 0, 1, 0, 0, F1, 0, 0);
		chk("deg2rad", stored, FRAU_PI_OVER_180);
		ex(FRAU_OP_DEG2RAD, 0, 1, 0, 0, F2, 0, 0);
		chk("deg2rad x2", stored, {FRAU_PI_OVER_180[31], FRAU_PI_OVER_180[30:23] + 8'h1, FRAU_PI_OVER_180[22:0]});
		ex(FRAU_OP_RAD2DEG, 0, 1, 0, 0, F1, 0, 0);
		chk("rad2deg", stored, FRAU_180_OVER_PI);
		ex(FRAU_OP_ADD, 0, 1, 0, 0, F2, F2, 0);
		chk("repeat runs", we_seen, 1'b1);
		chk("word order", stored, F4);
	endtask
	task automatic t_pulse;
		ex(FRAU_OP_ADD, 1, 0, 0, 0, F1, F1, 0);
		ex(FRAU_OP_ADD, 1, 1, 0, 0, F1, F1, 0);
		chk("pulse edge", stored, F2);
		ex(FRAU_OP_ADD, 1, 1, 0, 0, F2, F2, 0);
		chk("pulse held", we_seen, 1'b0);
		ex(FRAU_OP_RANGE, 1, 0, 0, 0, F1, F10, FH);
		ex(FRAU_OP_RANGE, 1, 1, 0, 0, F1, F10, FH);
		ex(FRAU_OP_RANGE, 1, 1, 0, 0, F1, F10, F5);
		chk("pulse range", rel, 3'h1);
	endtask
	// mid-run reset: relays drop and the pulse form forgets the held condition
	task automatic t_reset;
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		#1;
		chk("reset relays", rel, FRAU_RES_RESET);
		ex(FRAU_OP_RANGE, 1, 1, 0, 0, F1, F10, F20);
		chk("pulse after reset", rel, 3'h4);
	endtask
	task automatic report_and_stop;
		$display("mismatches %0d of %0d checks", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		t_range;
		t_swap_hold;
		t_arith;
		t_pulse;
		t_reset;
		report_and_stop;
	end
	// whole run is about 198 cycles; 2500 cycles, over twelve times that, means a hang
	initial begin
		#10000;
		n_mismatch++;
		report_and_stop;
	end
endmodule
`default_nettype wire
